// file: core/sdibc_core.sv
// Purpose: device side of four-bank command decode, burst cut-off
//          and concurrent auto precharge, with a small data store
// Assumes: controller on the same clock; no same-bank misuse
// Notes:   store keeps COL_BITS column bits per bank, rows ignored
// Contract
// R1: Chip select high acts as no-op
// R2: No-op keeps running operation going
// R3: Decode activate, read, write, precharge codes
// R4: Idle bank n restricts nothing on m
// R5: Busy bank n still allows commands elsewhere
// R6: Commands need clock enable high twice
// R7: Refresh and mode load need all idle
// R8: Burst terminate hits running burst only
// R9: Idle after precharge, active after activate delay
// R10: Auto precharge state starts at registration
// R11: Interrupted auto precharge burst self-precharges
// R12: Activate or precharge elsewhere keeps burst
// R13: Read to m replaces read data later
// R14: Write cuts read; mask one clock earlier
// R15: Read cuts write; last word one earlier
// R16: Write cuts write at registration
// R17: Read cuts auto-precharge read, precharge starts
// R18: Write cuts auto-precharge read, precharge starts
// R19: Read cuts AP write, precharge after recovery
// R20: Write cuts AP write, precharge after recovery
// R21: Interruption same with or without AP
// R22: Controller avoids undefined combinations
// R23: Mask gates writes now, reads two later
// R24: Address bit ten selects auto precharge
// R25: Controller tracks each bank separately
`timescale 1ns/100ps
module sdibc_core (
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic        clock_enable,
	input  wire logic        chip_select_n,
	input  wire logic        row_strobe_n,
	input  wire logic        column_strobe_n,
	input  wire logic        write_enable_n,
	input  wire logic [11:0] addr,
	input  wire logic [1:0]  bank_select,
	input  wire logic [1:0]  byte_mask,
	input  wire logic [15:0] dq_in,
	output logic      [15:0] dq_out,
	output logic      [15:0] dq_oe_n
);
	localparam int RCD_A = sdibc_pkg::ACT_TO_COL_CYC;
	localparam int TRP_A = sdibc_pkg::PRECHARGE_CYC;
	localparam int TWR_A = sdibc_pkg::WRITE_RECOV_CYC;
	localparam logic [2:0] RCD_LD = 3'(sdibc_pkg::ACT_TO_COL_CYC - 1);
	localparam logic [2:0] TRP_LD = 3'(sdibc_pkg::PRECHARGE_CYC - 1);
	localparam logic [2:0] TWR_LD = 3'(sdibc_pkg::WRITE_RECOV_CYC - 1);
	localparam logic [1:0] BL_LD  = 2'(sdibc_pkg::BURST_LEN - 1);

	logic        cke_prev_reg;
	logic        cmd_ok;
	logic [2:0]  cmd;
	logic        is_act;
	logic        is_rd;
	logic        is_wr;
	logic        is_pre;
	logic        is_bst;
	logic        col_cmd;
	logic        ap_sel;
	logic        burst_on_reg;
	logic        burst_rd_reg;
	logic        burst_ap_reg;
	logic [1:0]  burst_bank_reg;
	logic [3:0]  burst_col_reg;
	logic [1:0]  burst_cnt_reg;
	logic        stop_burst;
	logic        cont_beat;
	logic        burst_last;
	logic        beat;
	logic        beat_rd;
	logic [5:0]  beat_idx;
	logic [3:0]  beat_col;
	logic        ap_done;
	logic [15:0] mem_reg [sdibc_pkg::MEM_WORDS];
	logic [15:0] rd_data_reg;
	logic        rd_valid_reg;
	logic [1:0]  mask_q_reg;
	logic [15:0] dq_out_reg;
	logic [15:0] dq_oe_n_reg;
	logic [15:0] peek_word;

	// Commands count only with clock enable high on both edges
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cke_prev_reg <= 1'b0;
		end else begin
			cke_prev_reg <= clock_enable;
		end
	end

	// Decode; chip select high or no-op code yields no strobe
	assign cmd_ok  = clock_enable & cke_prev_reg & ~chip_select_n; // R1 R6
	assign cmd     = {row_strobe_n, column_strobe_n, write_enable_n};
	assign is_act  = cmd_ok & (cmd == sdibc_pkg::CMD_ACT); // R3
	assign is_rd   = cmd_ok & (cmd == sdibc_pkg::CMD_READ); // R3
	assign is_wr   = cmd_ok & (cmd == sdibc_pkg::CMD_WRITE); // R3
	assign is_pre  = cmd_ok & (cmd == sdibc_pkg::CMD_PRE); // R3
	assign is_bst  = cmd_ok & (cmd == sdibc_pkg::CMD_BST);
	assign col_cmd = is_rd | is_wr;
	assign ap_sel  = addr[sdibc_pkg::AP_BIT]; // R24

	// A new column command or terminate ends the running burst;
	// activate and precharge elsewhere leave it alone
	assign stop_burst = burst_on_reg & (col_cmd | is_bst // R8 R14 R15 R16
		| (is_pre & (ap_sel | (bank_select == burst_bank_reg)))); // R12
	assign cont_beat  = burst_on_reg & ~stop_burst; // R2
	assign burst_last = cont_beat & (burst_cnt_reg == 2'h1);
	assign beat       = col_cmd | cont_beat;
	assign beat_rd    = col_cmd ? is_rd : burst_rd_reg;
	assign beat_col   = col_cmd ? addr[3:0] : burst_col_reg;
	assign beat_idx   = col_cmd ? {bank_select, addr[3:0]} : {burst_bank_reg, burst_col_reg};
	// Cut or natural end of a burst that carries auto precharge
	assign ap_done    = burst_on_reg & burst_ap_reg & (stop_burst | burst_last); // R11 R21

	// Burst tracker, one burst on the die at a time
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			burst_on_reg   <= 1'b0;
			burst_rd_reg   <= 1'b0;
			burst_ap_reg   <= 1'b0;
			burst_bank_reg <= 2'h0;
			burst_col_reg  <= 4'h0;
			burst_cnt_reg  <= 2'h0;
		end else if (col_cmd) begin
			burst_on_reg   <= 1'b1; // R13 R21
			burst_rd_reg   <= is_rd;
			burst_ap_reg   <= ap_sel; // R24
			burst_bank_reg <= bank_select;
			burst_col_reg  <= {beat_col[3:2], beat_col[1:0] + 2'h1};
			burst_cnt_reg  <= BL_LD;
		end else if (stop_burst) begin
			burst_on_reg <= 1'b0; // R8
		end else if (cont_beat) begin
			// Sequential order wraps inside the burst
			burst_col_reg <= {burst_col_reg[3:2], burst_col_reg[1:0] + 2'h1};
			burst_cnt_reg <= burst_cnt_reg - 2'h1;
			if (burst_last) begin
				burst_on_reg <= 1'b0;
			end
		end
	end

	// Per-bank state and timers
	for (genvar b = 0; b < sdibc_pkg::BANKS; b++) begin : g_bank
		sdibc_pkg::sdibc_bank_state_type state_reg;
		sdibc_pkg::sdibc_bank_state_type state_next;
		logic [2:0] timer_reg;
		logic [2:0] timer_next;
		logic       here;
		logic       pre_here;

		assign here     = (bank_select == 2'(b));
		assign pre_here = is_pre & (ap_sel | here);

		// Next state; a burst on bank m touches only bank m, and only via ap_done
		always_comb begin
			state_next = state_reg;
			timer_next = (timer_reg != 3'h0) ? timer_reg - 3'h1 : 3'h0;
			unique case (state_reg)
				sdibc_pkg::BS_IDLE: begin
					if (is_act && here) begin
						state_next = sdibc_pkg::BS_ACTIVATING;
						timer_next = RCD_LD;
					end
				end
				sdibc_pkg::BS_ACTIVATING, sdibc_pkg::BS_ACTIVE: begin
					if (pre_here) begin
						state_next = sdibc_pkg::BS_PRECHARGING;
						timer_next = TRP_LD;
					end else if (col_cmd && here && ap_sel) begin
						state_next = sdibc_pkg::BS_AP_PENDING; // R10
					end else if (state_reg == sdibc_pkg::BS_ACTIVATING && timer_reg == 3'h0) begin
						state_next = sdibc_pkg::BS_ACTIVE; // R9
					end
				end
				sdibc_pkg::BS_PRECHARGING: begin
					if (timer_reg == 3'h0) begin
						state_next = sdibc_pkg::BS_IDLE; // R9
					end
				end
				sdibc_pkg::BS_AP_PENDING: begin
					if (col_cmd && here && ap_sel) begin
						state_next = sdibc_pkg::BS_AP_PENDING;
					end else if (ap_done && burst_bank_reg == 2'(b)) begin
						if (burst_rd_reg) begin
							state_next = sdibc_pkg::BS_PRECHARGING; // R11 R17 R18
							timer_next = TRP_LD;
						end else begin
							// Write data must settle before the row closes
							state_next = sdibc_pkg::BS_WR_RECOVERY; // R19 R20
							timer_next = TWR_LD;
						end
					end
				end
				sdibc_pkg::BS_WR_RECOVERY: begin
					if (timer_reg == 3'h0) begin
						state_next = sdibc_pkg::BS_PRECHARGING; // R19 R20
						timer_next = TRP_LD;
					end
				end
				default: begin
					state_next = sdibc_pkg::BS_IDLE;
				end
			endcase
		end

		// Bank registers
		always_ff @(posedge clk or negedge rstn) begin
			if (!rstn) begin
				state_reg <= sdibc_pkg::BS_IDLE;
				timer_reg <= 3'h0;
			end else begin
				state_reg <= state_next;
				timer_reg <= timer_next;
			end
		end
	end

	// Store; write mask acts with no delay, last word is the
	// one registered before the cutting command
	always_ff @(posedge clk) begin
		if (beat && !beat_rd) begin
			if (!byte_mask[0]) begin
				mem_reg[beat_idx][7:0] <= dq_in[7:0]; // R15 R16 R23
			end
			if (!byte_mask[1]) begin
				mem_reg[beat_idx][15:8] <= dq_in[15:8]; // R23
			end
		end
	end

	// Read path: one stage plus output flop gives the latency;
	// data already in flight still leaves, so a new read takes over
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rd_data_reg  <= 16'h0000;
			rd_valid_reg <= 1'b0;
			mask_q_reg   <= sdibc_pkg::MASK_RST;
		end else begin
			rd_data_reg  <= mem_reg[beat_idx];
			rd_valid_reg <= beat & beat_rd; // R13 R15
			mask_q_reg   <= byte_mask; // R23
		end
	end

	// Drivers; mask seen two edges back turns a lane off, which is
	// how the controller keeps the bus free before a write
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			dq_out_reg  <= 16'h0000;
			dq_oe_n_reg <= 16'hffff;
		end else begin
			dq_out_reg  <= rd_data_reg;
			dq_oe_n_reg <= {{8{~(rd_valid_reg & ~mask_q_reg[1])}},
			                {8{~(rd_valid_reg & ~mask_q_reg[0])}}}; // R14 R18 R23
		end
	end

	assign dq_out  = dq_out_reg;
	assign dq_oe_n = dq_oe_n_reg;

	// Word the read stage picks up this cycle, kept for the latency check
	assign peek_word = mem_reg[beat_idx];

	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	inhibit_holds_a: assert property ( // R1
		(chip_select_n && burst_on_reg && burst_cnt_reg > 2'h1) |=> burst_on_reg)
		else $error("burst stopped on inhibit");
	nop_holds_a: assert property ( // R2
		(cmd_ok && cmd == sdibc_pkg::CMD_NOP && burst_on_reg && burst_cnt_reg == 2'h3)
		|=> burst_on_reg && burst_cnt_reg == 2'h2)
		else $error("burst stopped on no-op");
	bst_stops_a: assert property ( // R8
		is_bst |=> !burst_on_reg)
		else $error("terminate left burst running");
	act_timing_a: assert property ( // R9
		(is_act && bank_select == 2'h0 && g_bank[0].state_reg == sdibc_pkg::BS_IDLE && !is_pre)
		##1 (!is_pre && !col_cmd)[*3]
		|-> (g_bank[0].state_reg == sdibc_pkg::BS_ACTIVE))
		else $error("row not active after activate delay");
	ap_enter_a: assert property ( // R10
		(col_cmd && ap_sel && bank_select == 2'h2 && !is_pre
		 && g_bank[2].state_reg == sdibc_pkg::BS_ACTIVE)
		|=> g_bank[2].state_reg == sdibc_pkg::BS_AP_PENDING)
		else $error("auto precharge state not entered");
	rd_cap_a: assert property ( // R17
		(burst_on_reg && burst_ap_reg && burst_rd_reg && burst_bank_reg == 2'h0
		 && is_rd && bank_select != 2'h0)
		|=> g_bank[0].state_reg == sdibc_pkg::BS_PRECHARGING
		##TRP_A g_bank[0].state_reg == sdibc_pkg::BS_IDLE)
		else $error("concurrent precharge wrong");
	wr_cap_a: assert property ( // R19
		(burst_on_reg && burst_ap_reg && !burst_rd_reg && burst_bank_reg == 2'h2
		 && col_cmd && bank_select != 2'h2)
		|=> g_bank[2].state_reg == sdibc_pkg::BS_WR_RECOVERY
		##TWR_A g_bank[2].state_reg == sdibc_pkg::BS_PRECHARGING)
		else $error("write recovery before precharge wrong");
	act_keeps_a: assert property ( // R12
		(is_act && burst_on_reg && burst_cnt_reg > 2'h1) |=> burst_on_reg)
		else $error("activate elsewhere cut burst");
	rd_latency_a: assert property ( // R13
		(is_rd && byte_mask == 2'h0) ##1 (byte_mask == 2'h0) |-> ##1 dq_oe_n == 16'h0000
		&& dq_out == $past(peek_word, 2))
		else $error("read data not at latency");
	rd_mask_a: assert property ( // R23
		(byte_mask == 2'h3) |-> ##2 dq_oe_n == 16'hffff)
		else $error("read mask delay wrong");
	wr_store_a: assert property ( // R16
		(beat && !beat_rd && byte_mask == 2'h0)
		|=> mem_reg[$past(beat_idx)] == $past(dq_in))
		else $error("write word not stored");

	// Bank precharge elsewhere must not cut the burst
	pre_keeps_a: assert property ( // R12
		(is_pre && !ap_sel && bank_select != burst_bank_reg && burst_on_reg && burst_cnt_reg > 2'h1)
		|=> burst_on_reg)
		else $error("precharge elsewhere cut burst");
	// A write cuts the read; nothing of it leaves after the pipe drains
	wr_cuts_rd_a: assert property ( // R14
		(is_wr && burst_on_reg && burst_rd_reg) |-> ##2 dq_oe_n == 16'hffff)
		else $error("cut read still driving");
	// Clock enable low on the previous edge blocks a command
	cke_gate_a: assert property ( // R6
		(!cke_prev_reg && !chip_select_n && cmd == sdibc_pkg::CMD_WRITE && !burst_on_reg)
		|=> !burst_on_reg)
		else $error("command taken without clock enable history");

	// Main scenarios
	bst_stop_c: cover property (is_bst && burst_on_reg);
	pre_mid_burst_c: cover property (is_pre && burst_on_reg && !stop_burst);
	rd_over_rd_c: cover property (burst_on_reg && burst_rd_reg && is_rd
		&& bank_select != burst_bank_reg);
	wr_cut_ap_c: cover property (ap_done && !burst_rd_reg && col_cmd);
	full_burst_c: cover property (burst_last && burst_rd_reg);
endmodule

// file: inc/sdibc_pkg.sv
// Purpose: constants and types for the four-bank command core
// Assumes: 100 MHz clock, burst length and latency fixed
// Notes:   times in ns, cycle counts derived from them
package sdibc_pkg;
	// Clock
	localparam int CLK_PERIOD_NS = 10;
	// Bank timing in ns
	localparam int ACT_TO_COL_NS  = 20;
	localparam int PRECHARGE_NS   = 20;
	localparam int WRITE_RECOV_NS = 15;
	// Least times round up to whole cycles
	localparam int ACT_TO_COL_CYC  = (ACT_TO_COL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PRECHARGE_CYC   = (PRECHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WRITE_RECOV_CYC = (WRITE_RECOV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TIMER_W         = 3;
	// Access shape
	localparam int BURST_LEN      = 4;
	localparam int READ_LATENCY   = 2;
	localparam int MASK_RD_DELAY  = 2;
	localparam int ADDR_W         = 12;
	localparam int DATA_W         = 16;
	localparam int BANKS          = 4;
	localparam int COL_BITS       = 4;
	localparam int AP_BIT         = 10;
	localparam int MEM_WORDS      = BANKS * (1 << COL_BITS);
	// Command codes as {row_strobe_n, column_strobe_n, write_enable_n}
	localparam logic [2:0] CMD_NOP   = 3'h7;
	localparam logic [2:0] CMD_ACT   = 3'h3;
	localparam logic [2:0] CMD_READ  = 3'h5;
	localparam logic [2:0] CMD_WRITE = 3'h4;
	localparam logic [2:0] CMD_PRE   = 3'h2;
	localparam logic [2:0] CMD_BST   = 3'h6;
	// Reset values
	localparam logic [1:0] MASK_RST = 2'h3;
	// Bank states
	typedef enum logic [2:0] {
		BS_IDLE,
		BS_ACTIVATING,
		BS_ACTIVE,
		BS_PRECHARGING,
		BS_AP_PENDING,
		BS_WR_RECOVERY
	} sdibc_bank_state_type;
endpackage

// file: verif/sdibc_ctrl_model.sv
// Purpose: controller stand-in driving command, mask and write data lines
// Assumes: exactly one call of put or nop per clock cycle
// Notes:   idle data lines toggle so a stale word never passes as valid
`timescale 1ns/100ps
module sdibc_ctrl_model (
	input  wire logic        clk,
	output logic             clock_enable,
	output logic             chip_select_n,
	output logic             row_strobe_n,
	output logic             column_strobe_n,
	output logic             write_enable_n,
	output logic      [11:0] addr,
	output logic      [1:0]  bank_select,
	output logic      [1:0]  byte_mask,
	output logic      [15:0] dq_in
);
	logic inhibit = 1'b0;
	logic cke_on  = 1'b1;

	// Bus idles as an inhibited no-op
	initial begin
		clock_enable = 1'b1;
		chip_select_n = 1'b1;
		{row_strobe_n, column_strobe_n, write_enable_n} = sdibc_pkg::CMD_NOP;
		addr = 12'h000;
		bank_select = 2'h0;
		byte_mask = 2'h0;
		dq_in = 16'h0000;
	end

	// Only legal bank and command pairs; no refresh or mode codes, stop on running burst
	task automatic put(input logic [2:0] code, input logic [1:0] bank, input logic [11:0] a,
		input logic [15:0] d, input logic [1:0] m);
		@(posedge clk);
		#1;
		clock_enable = cke_on;
		chip_select_n = inhibit;
		{row_strobe_n, column_strobe_n, write_enable_n} = code;
		addr = a;
		bank_select = bank;
		byte_mask = m;
		dq_in = d;
	endtask

	// Released lines show the inverse of what they last carried
	task automatic nop(input logic [1:0] m);
		put(sdibc_pkg::CMD_NOP, ~bank_select, ~addr, ~dq_in, m);
	endtask
endmodule

// file: verif/tb_sdram_interbank_command_rules.sv
// Purpose: directed scenarios for inter-bank cut-off and auto precharge
// Assumes: read latency two, burst four, two-cycle bank timings
// Notes:   bank states are read through the core's bank instances
`timescale 1ns/100ps
module tb_sdram_interbank_command_rules;
	logic        clk;
	logic        rstn;
	logic        clock_enable;
	logic        chip_select_n;
	logic        row_strobe_n;
	logic        column_strobe_n;
	logic        write_enable_n;
	logic [11:0] addr;
	logic [1:0]  bank_select;
	logic [1:0]  byte_mask;
	logic [15:0] dq_in;
	logic [15:0] dq_out;
	logic [15:0] dq_oe_n;
	int          mismatches  = 0;
	int          comparisons = 0;
	logic [11:0] spare_bits  = 12'h5a5;

	sdibc_ctrl_model i_ctrl (.clk(clk), .clock_enable(clock_enable), .chip_select_n(chip_select_n),
		.row_strobe_n(row_strobe_n), .column_strobe_n(column_strobe_n), .write_enable_n(write_enable_n),
		.addr(addr), .bank_select(bank_select), .byte_mask(byte_mask), .dq_in(dq_in));
	sdibc_core i_dut (.clk(clk), .rstn(rstn), .clock_enable(clock_enable), .chip_select_n(chip_select_n),
		.row_strobe_n(row_strobe_n), .column_strobe_n(column_strobe_n), .write_enable_n(write_enable_n),
		.addr(addr), .bank_select(bank_select), .byte_mask(byte_mask), .dq_in(dq_in),
		.dq_out(dq_out), .dq_oe_n(dq_oe_n));

	// Free-running 100 MHz clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic results();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask

	task automatic cmd(input logic [2:0] c, input logic [1:0] b, input logic [11:0] a, input logic [15:0] d);
		// Row bits vary; column bits and bit ten stay as given
		i_ctrl.put(c, b, a | (spare_bits & 12'hbf0), d, 2'h0);
		spare_bits = spare_bits + 12'h1d0;
	endtask

	// Write of n consecutive words; n below four leaves it for the next command to cut
	task automatic wr(input logic [1:0] b, input int n, input logic [15:0] w);
		cmd(sdibc_pkg::CMD_WRITE, b, 12'h000, w);
		for (int k = 1; k < n; k++) begin
			cmd(sdibc_pkg::CMD_NOP, 2'h0, 12'h000, w + 16'(k));
		end
	endtask

	// Words already in flight, one per cycle, first one checked at once
	task automatic beats(input logic [15:0] e [$]);
		foreach (e[k]) begin
			if (k > 0) i_ctrl.nop(2'h0);
			chk("read word", e[k], dq_out);
			chk("drive enable", 16'h0000, dq_oe_n);
		end
		i_ctrl.nop(2'h0);
		chk("drive enable", 16'hffff, dq_oe_n);
	endtask

	task automatic rd(input logic [1:0] b, input logic [15:0] e [$]);
		cmd(sdibc_pkg::CMD_READ, b, 12'h000, 16'h0000);
		i_ctrl.nop(2'h0);
		i_ctrl.nop(2'h0);
		beats(e);
	endtask

	function automatic logic [15:0] st(input int k);
		return (k == 0) ? 16'(i_dut.g_bank[0].state_reg) : 16'(i_dut.g_bank[2].state_reg);
	endfunction

	task automatic s_cuts();
		cmd(sdibc_pkg::CMD_ACT, 2'h0, 12'h000, 16'h0000);
		cmd(sdibc_pkg::CMD_ACT, 2'h1, 12'h000, 16'h0000);
		i_ctrl.nop(2'h0);
		i_ctrl.nop(2'h0);
		wr(2'h0, 4, 16'ha000);
		wr(2'h1, 4, 16'hb000);
		rd(2'h0, '{16'ha000, 16'ha001, 16'ha002, 16'ha003});
		wr(2'h0, 2, 16'hc000);
		wr(2'h1, 4, 16'hd000);
		rd(2'h0, '{16'hc000, 16'hc001, 16'ha002, 16'ha003});
		wr(2'h0, 3, 16'he000);
		rd(2'h1, '{16'hd000, 16'hd001, 16'hd002, 16'hd003});
		rd(2'h0, '{16'he000, 16'he001, 16'he002, 16'ha003});
		cmd(sdibc_pkg::CMD_READ, 2'h0, 12'h000, 16'h0000);
		i_ctrl.nop(2'h0);
		cmd(sdibc_pkg::CMD_READ, 2'h1, 12'h000, 16'h0000);
		beats('{16'he000, 16'he001, 16'hd000, 16'hd001, 16'hd002, 16'hd003});
		$display("test cuts done");
	endtask

	task automatic s_keep_mask();
		i_ctrl.put(sdibc_pkg::CMD_READ, 2'h0, 12'h000, 16'h0000, 2'h1);
		cmd(sdibc_pkg::CMD_PRE, 2'h3, 12'h000, 16'h0000);
		cmd(sdibc_pkg::CMD_ACT, 2'h3, 12'h000, 16'h0000);
		chk("drive enable", 16'h00ff, dq_oe_n);
		chk("read word", 16'he000, dq_out);
		i_ctrl.nop(2'h0);
		chk("read word", 16'he001, dq_out);
		i_ctrl.nop(2'h0);
		chk("read word", 16'he002, dq_out);
		i_ctrl.nop(2'h0);
		chk("read word", 16'ha003, dq_out);
		i_ctrl.nop(2'h0);
		i_ctrl.nop(2'h0);
		cmd(sdibc_pkg::CMD_READ, 2'h0, 12'h000, 16'h0000);
		i_ctrl.nop(2'h0);
		i_ctrl.nop(2'h3);
		chk("read word", 16'he000, dq_out);
		cmd(sdibc_pkg::CMD_WRITE, 2'h1, 12'h000, 16'h5a00);
		chk("read word", 16'he001, dq_out);
		chk("drive enable", 16'h0000, dq_oe_n);
		cmd(sdibc_pkg::CMD_NOP, 2'h0, 12'h000, 16'h5a01);
		chk("drive enable", 16'hffff, dq_oe_n);
		cmd(sdibc_pkg::CMD_NOP, 2'h0, 12'h000, 16'h5a02);
		cmd(sdibc_pkg::CMD_NOP, 2'h0, 12'h000, 16'h5a03);
		rd(2'h1, '{16'h5a00, 16'h5a01, 16'h5a02, 16'h5a03});
		$display("test keep and mask done");
	endtask

	task automatic s_ignore();
		i_ctrl.inhibit = 1'b1;
		wr(2'h0, 4, 16'hf000);
		i_ctrl.inhibit = 1'b0;
		i_ctrl.cke_on = 1'b0;
		i_ctrl.nop(2'h0);
		i_ctrl.cke_on = 1'b1;
		wr(2'h0, 4, 16'hf100);
		rd(2'h0, '{16'he000, 16'he001, 16'he002, 16'ha003});
		$display("test ignore done");
	endtask

	// Terminate ends the running burst; words in flight still leave
	task automatic s_stop();
		cmd(sdibc_pkg::CMD_READ, 2'h0, 12'h000, 16'h0000);
		i_ctrl.nop(2'h0);
		cmd(sdibc_pkg::CMD_BST, 2'h0, 12'h000, 16'h0000);
		beats('{16'he000, 16'he001});
		$display("test stop done");
	endtask

	// Read then write with auto precharge, each cut by a read to bank one
	task automatic s_ap();
		for (int k = 0; k < 2; k++) begin
			if (k == 1) begin
				cmd(sdibc_pkg::CMD_ACT, 2'h2, 12'h000, 16'h0000);
				i_ctrl.nop(2'h0);
				i_ctrl.nop(2'h0);
			end
			cmd(k ? sdibc_pkg::CMD_WRITE : sdibc_pkg::CMD_READ, 2'(2 * k), 12'h400, 16'h1234);
			i_ctrl.nop(2'h0);
			chk("bank state", 16'(sdibc_pkg::BS_AP_PENDING), st(k));
			cmd(sdibc_pkg::CMD_READ, 2'h1, 12'h000, 16'h0000);
			i_ctrl.nop(2'h0);
			i_ctrl.nop(2'h0);
			chk("bank state", k ? 16'(sdibc_pkg::BS_WR_RECOVERY) : 16'(sdibc_pkg::BS_PRECHARGING), st(k));
			repeat (6) i_ctrl.nop(2'h0);
		end
		$display("test auto precharge done");
	endtask

	// Reset for five cycles, then two idle edges before the first command
	initial begin
		rstn = 1'b0;
		repeat (5) @(posedge clk);
		#1;
		rstn = 1'b1;
		i_ctrl.nop(2'h0);
		i_ctrl.nop(2'h0);
		s_cuts();
		s_keep_mask();
		s_ignore();
		s_stop();
		s_ap();
		results();
	end

	// Hang guard well beyond the scenario length
	initial begin
		#100000;
		mismatches++;
		results();
	end
endmodule
